// ==== rtl/adc_result_buffer_formatter.sv ====
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module adc_result_buffer_formatter #(
	parameter int NUM_CH = 16,
	parameter int NUM_CORES = 4,
	localparam int CORE_W = $clog2(NUM_CORES + 1)
) (
	input wire logic REF_CLK, // System clock, 50 MHz.
	input wire logic RST, // Asynchronous reset, active high.
	input wire logic PSEL, // APB select.
	input wire logic PENABLE, // APB access phase.
	input wire logic PWRITE, // APB direction, high for write.
	input wire logic [adc_result_pkg::ADDR_W-1:0] PADDR, // APB byte address.
	input wire logic [adc_result_pkg::DATA_W-1:0] PWDATA, // APB write data.
	input wire logic [3:0] PSTRB, // APB write byte strobes.
	output logic [adc_result_pkg::DATA_W-1:0] PRDATA, // APB read data.
	output logic PREADY, // APB transfer done.
	output logic PSLVERR, // APB error answer.
	output logic IRQ, // Unmasked result event pending.
	output logic [NUM_CH-1:0] CH_READY, // Per-channel interrupt request.
	input wire logic RESULT_VALID, // One-cycle strobe from a core.
	input wire logic [4:0] RESULT_CHANNEL, // Channel of the result.
	input wire logic [CORE_W-1:0] RESULT_CORE, // Core index; NUM_CORES is the shared core.
	input wire logic [adc_result_pkg::RAW_W-1:0] RESULT_DATA // Raw code, right-aligned.
);
	localparam int MAX_CH = adc_result_pkg::MAX_CH;
	localparam int DATA_W = adc_result_pkg::DATA_W;
	localparam int ADDR_W = adc_result_pkg::ADDR_W;
	localparam int WORD_W = adc_result_pkg::WORD_W;
	localparam int HALF = adc_result_pkg::CH_PER_HALF;
	localparam int AB = adc_result_pkg::ALIGN_BITS;
	localparam logic [ADDR_W-1:0] CORE_END =
		ADDR_W'(adc_result_pkg::CORE_CFG_BASE + adc_result_pkg::WORD_BYTES * NUM_CORES);
	localparam logic [ADDR_W-1:0] BUFFER_END =
		ADDR_W'(adc_result_pkg::BUFFER_BASE + adc_result_pkg::WORD_BYTES * NUM_CH);

	// Register map, one aligned 32-bit word per register, byte addresses.
	// The control word holds the global fractional select in bit 0.
	// The same control word holds the shared core's resolution code in bits 9 and 8.
	// The low mode word covers channels 0 to 15, two bits per channel.
	// The high mode word covers channels 16 to 31 in the same layout.
	// Within a pair, the lower bit selects signed output and the upper bit differential input.
	// The two status words hold the ready flags of the low and the high channel halves.
	// The status words are read-only; a write to them is answered but changes nothing.
	// The event word holds one sticky bit per channel and is cleared by writing ones.
	// The mask word has the same layout and selects which events reach the summary request.
	// Each dedicated core has its own configuration word holding its resolution code.
	// Configuration words exist only for the cores that this instance really has.
	// Each channel has one result buffer word; only its low sixteen bits carry data.
	// Reading a buffer word clears that channel's ready flag; writing it does nothing.
	// Any address outside these words, or not aligned to a word, answers with an error.
	// An erroring access has no effect and returns zero read data.
	//
	// Bus timing.
	// Every transfer takes exactly one access cycle; the slave never inserts wait states.
	// Read data is chosen from the setup cycle's address and shown in the access cycle.
	// Because of that, a result stored during the setup cycle is not in the returned word.
	// The read still clears its ready flag, so the next poll misses it; only a result stored in the access cycle keeps its flag.
	// Back-to-back transfers are fine; a new setup may follow an access at once.
	//
	// Result path timing.
	// A result is stored at the edge where its strobe is seen, together with its flags.
	// The stored word is readable by a setup cycle that starts in the following cycle.
	// The per-channel request outputs follow the ready flags one cycle later.
	// The summary request follows the masked event bits one cycle later as well.
	// Those extra flops keep every output straight from a register, at one cycle of latency.
	// Results for channels that this instance lacks are dropped without any trace.
	// A core index at or above the number of dedicated cores selects the shared core.
	//
	// Ready flag versus event bit.
	// The ready flag tracks whether the newest stored word has been read.
	// The event bit tracks whether software has acknowledged the arrival of any result.
	// They are kept apart so that polling software and interrupt software do not interfere.
	// In both, a set and a clear in the same cycle leave the bit set.
	// Losing the set would hide a fresh result, which is worse than one spurious wakeup.
	//
	// Formatting.
	// The raw code is first pushed to the top of a twelve-bit field by the resolution gap.
	// A signed differential code has its top bit inverted to turn offset binary signed.
	// A signed single-ended code is already taken as two's complement.
	// Fractional words keep the aligned field at the top with zeros below it.
	// Integer words shift the field back down, filling with zeros or with the sign.
	// Unused high bits of the raw code are dropped by the left alignment.
	//
	// Limitations.
	// There is no overrun indication; an unread word is simply replaced by a newer one.
	// Resolution changes apply to the next result only; stored words are not reformatted.
	// Mode and format changes likewise affect only results stored after the change.

	generate
		if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
			$error("NUM_CH must lie between 1 and 32");
		end
		if (NUM_CORES < 1 || NUM_CORES > adc_result_pkg::MAX_CORES) begin : g_bad_cores
			$error("NUM_CORES must lie between 1 and 8");
		end
	endgenerate

	// Control state.
	logic fractional_select;
	adc_result_pkg::resolution_t shared_core_resolution;
	adc_result_pkg::resolution_t dedicated_core_resolution [NUM_CORES];
	logic [MAX_CH-1:0] channel_signed_select;
	logic [MAX_CH-1:0] channel_differential_select;
	logic [MAX_CH-1:0] irq_mask;

	// Block state.
	logic [WORD_W-1:0] channel_result_buffer [NUM_CH];
	logic [MAX_CH-1:0] channel_result_ready;
	logic [MAX_CH-1:0] irq_status;
	logic [DATA_W-1:0] next_prdata;
	logic next_pslverr;

	// Bus decode.
	wire setup = PSEL & ~PENABLE;
	wire access_done = PSEL & PENABLE & PREADY;
	wire wr_ok = access_done & PWRITE & ~PSLVERR;
	wire rd_ok = access_done & ~PWRITE & ~PSLVERR;
	wire aligned = PADDR[AB-1:0] == '0;
	wire hit_ctrl = PADDR == adc_result_pkg::CTRL_OFS;
	wire hit_mode_low = PADDR == adc_result_pkg::MODE_LOW_OFS;
	wire hit_mode_high = PADDR == adc_result_pkg::MODE_HIGH_OFS;
	wire hit_status_low = PADDR == adc_result_pkg::STATUS_LOW_OFS;
	wire hit_status_high = PADDR == adc_result_pkg::STATUS_HIGH_OFS;
	wire hit_irq_status = PADDR == adc_result_pkg::IRQ_STATUS_OFS;
	wire hit_irq_mask = PADDR == adc_result_pkg::IRQ_MASK_OFS;
	wire hit_core = aligned && PADDR >= adc_result_pkg::CORE_CFG_BASE && PADDR < CORE_END;
	wire hit_buffer = aligned && PADDR >= adc_result_pkg::BUFFER_BASE && PADDR < BUFFER_END;
	wire hit_any = hit_ctrl | hit_mode_low | hit_mode_high | hit_status_low | hit_status_high |
		hit_irq_status | hit_irq_mask | hit_core | hit_buffer;
	wire [ADDR_W-1:0] core_ofs = PADDR - adc_result_pkg::CORE_CFG_BASE;
	wire [ADDR_W-1:0] buffer_ofs = PADDR - adc_result_pkg::BUFFER_BASE;
	wire [ADDR_W-AB-1:0] core_index = core_ofs[ADDR_W-1:AB];
	wire [ADDR_W-AB-1:0] buffer_index = buffer_ofs[ADDR_W-1:AB];
	wire [DATA_W-1:0] byte_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
	wire [DATA_W-1:0] clear_bits = PWDATA & byte_mask;

	// Result path: pick the converting core's resolution and the channel's sign options.
	wire result_in_range = RESULT_VALID && 32'(RESULT_CHANNEL) < NUM_CH;
	wire result_shared = 32'(RESULT_CORE) >= NUM_CORES;
	wire [$clog2(NUM_CORES)-1:0] core_pick = RESULT_CORE[$clog2(NUM_CORES)-1:0];
	wire [4:0] chan_pick = RESULT_CHANNEL;

	result_format_if fmt_bus();

	assign fmt_bus.raw = RESULT_DATA;
	assign fmt_bus.resolution = result_shared ? shared_core_resolution :
		dedicated_core_resolution[core_pick];
	assign fmt_bus.fractional = fractional_select;
	assign fmt_bus.signed_fractional_select = channel_signed_select[chan_pick];
	assign fmt_bus.differential = channel_differential_select[chan_pick];

	result_formatter u_formatter (
		.fmt(fmt_bus.formatter)
	);

	// Global control register.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			fractional_select <= adc_result_pkg::RESET_FRAC;
			shared_core_resolution <= adc_result_pkg::RESET_RES;
		end else if (wr_ok && hit_ctrl) begin
			if (PSTRB[0]) begin
				fractional_select <= PWDATA[adc_result_pkg::CTRL_FRAC_BIT];
			end
			if (PSTRB[1]) begin
				shared_core_resolution <=
					PWDATA[adc_result_pkg::CTRL_SHARED_RES_LSB +: 2];
			end
		end
	end

	// Interrupt mask; the byte strobes keep unselected lanes.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			irq_mask <= '0;
		end else if (wr_ok && hit_irq_mask) begin
			irq_mask <= (irq_mask & ~byte_mask) | (PWDATA & byte_mask);
		end
	end

	// Per-core resolution fields.
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CORES; gc++) begin : g_core
			wire core_wr = wr_ok && hit_core && 32'(core_index) == gc && PSTRB[0];
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					dedicated_core_resolution[gc] <= adc_result_pkg::RESET_RES;
				end else if (core_wr) begin
					dedicated_core_resolution[gc] <=
						PWDATA[adc_result_pkg::CORE_RES_LSB +: 2];
				end
			end
		end
	endgenerate

	// Per-channel state: mode bits, ready flag, event flag and result buffer.
	genvar gi;
	generate
		for (gi = 0; gi < MAX_CH; gi++) begin : g_ch
			localparam int POS = (gi % HALF) * adc_result_pkg::MODE_BITS;
			localparam bit EXISTS = gi < NUM_CH;
			wire mode_hit = (gi < HALF) ? hit_mode_low : hit_mode_high;
			wire mode_wr = EXISTS && wr_ok && mode_hit && byte_mask[POS];
			wire store = EXISTS && result_in_range && 32'(RESULT_CHANNEL) == gi;
			wire taken = rd_ok && hit_buffer && 32'(buffer_index) == gi;
			wire ack = wr_ok && hit_irq_status && clear_bits[gi];

			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					channel_signed_select[gi] <= 1'b0;
					channel_differential_select[gi] <= 1'b0;
				end else if (mode_wr) begin
					channel_signed_select[gi] <=
						PWDATA[POS + adc_result_pkg::MODE_SIGNED_BIT];
					channel_differential_select[gi] <=
						PWDATA[POS + adc_result_pkg::MODE_DIFF_BIT];
				end
			end

			// A store in the same cycle as the read wins, so the new word stays flagged.
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					channel_result_ready[gi] <= 1'b0;
				end else begin
					channel_result_ready[gi] <= store | (channel_result_ready[gi] & ~taken);
				end
			end

			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					irq_status[gi] <= 1'b0;
				end else begin
					irq_status[gi] <= store | (irq_status[gi] & ~ack);
				end
			end

			if (EXISTS) begin : g_buf
				// Only the result path writes here; bus writes never reach it.
				always_ff @(posedge REF_CLK or posedge RST) begin
					if (RST) begin
						channel_result_buffer[gi] <= '0;
					end else if (store) begin
						channel_result_buffer[gi] <= fmt_bus.word;
					end
				end
			end
		end
	endgenerate

	// Read selection, taken in the setup cycle.
	wire [DATA_W-1:0] ctrl_word = DATA_W'({shared_core_resolution,
		{(adc_result_pkg::CTRL_SHARED_RES_LSB - 1){1'b0}}, fractional_select});
	logic [DATA_W-1:0] mode_word;
	logic [DATA_W-1:0] mode_word_high;
	always_comb begin
		mode_word = '0;
		mode_word_high = '0;
		for (int i = 0; i < HALF; i++) begin
			mode_word[i * adc_result_pkg::MODE_BITS + adc_result_pkg::MODE_SIGNED_BIT] =
				channel_signed_select[i];
			mode_word[i * adc_result_pkg::MODE_BITS + adc_result_pkg::MODE_DIFF_BIT] =
				channel_differential_select[i];
			mode_word_high[i * adc_result_pkg::MODE_BITS + adc_result_pkg::MODE_SIGNED_BIT] =
				channel_signed_select[i + HALF];
			mode_word_high[i * adc_result_pkg::MODE_BITS + adc_result_pkg::MODE_DIFF_BIT] =
				channel_differential_select[i + HALF];
		end
	end

	wire [DATA_W-1:0] status_low_word = DATA_W'(channel_result_ready[HALF-1:0]);
	wire [DATA_W-1:0] status_high_word = DATA_W'(channel_result_ready[MAX_CH-1:HALF]);
	wire [DATA_W-1:0] core_word = DATA_W'(dedicated_core_resolution[core_index[$clog2(NUM_CORES)-1:0]]);
	wire [DATA_W-1:0] buffer_word =
		DATA_W'(channel_result_buffer[buffer_index[$clog2(NUM_CH > 1 ? NUM_CH : 2)-1:0]]);

	always_comb begin
		next_prdata = '0;
		if (hit_ctrl) begin
			next_prdata = ctrl_word;
		end else if (hit_mode_low) begin
			next_prdata = mode_word;
		end else if (hit_mode_high) begin
			next_prdata = mode_word_high;
		end else if (hit_status_low) begin
			next_prdata = status_low_word;
		end else if (hit_status_high) begin
			next_prdata = status_high_word;
		end else if (hit_irq_status) begin
			next_prdata = irq_status;
		end else if (hit_irq_mask) begin
			next_prdata = irq_mask;
		end else if (hit_core) begin
			next_prdata = core_word;
		end else if (hit_buffer) begin
			next_prdata = buffer_word;
		end
	end

	// Writes to read-only words are accepted silently; only unmapped addresses fail.
	assign next_pslverr = ~hit_any;

	// Fixed one access cycle: the answer is prepared in setup and shown in access.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= '0;
		end else begin
			PREADY <= setup;
			PSLVERR <= setup & next_pslverr;
			PRDATA <= (setup && !PWRITE && !next_pslverr) ? next_prdata : '0;
		end
	end

	// Outputs come from flops; the level requests follow the flags one cycle late.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
			CH_READY <= '0;
		end else begin
			IRQ <= |(irq_status & irq_mask);
			CH_READY <= channel_result_ready[NUM_CH-1:0];
		end
	end

endmodule

`default_nettype wire

// ==== rtl/adc_result_pkg.sv ====
package adc_result_pkg;

	// Ceilings that the register layout can serve.
	localparam int MAX_CH = 32;
	localparam int MAX_CORES = 8;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int RAW_W = 12;
	localparam int WORD_W = 16;
	localparam int FRAC_PAD_W = WORD_W - RAW_W;

	typedef logic [1:0] resolution_t;
	localparam resolution_t RES_6 = 2'h0;
	localparam resolution_t RES_8 = 2'h1;
	localparam resolution_t RES_10 = 2'h2;
	localparam resolution_t RES_12 = 2'h3;
	// Each resolution step below 12 bits drops this many result bits.
	localparam int RES_STEP_BITS = 2;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] MODE_LOW_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] MODE_HIGH_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] STATUS_LOW_OFS = 12'h00C;
	localparam logic [ADDR_W-1:0] STATUS_HIGH_OFS = 12'h010;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h014;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h018;
	localparam logic [ADDR_W-1:0] CORE_CFG_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] BUFFER_BASE = 12'h100;
	localparam int WORD_BYTES = 4;
	localparam int ALIGN_BITS = 2;

	// Field positions.
	localparam int CTRL_FRAC_BIT = 0;
	localparam int CTRL_SHARED_RES_LSB = 8;
	localparam int CORE_RES_LSB = 0;
	localparam int MODE_SIGNED_BIT = 0;
	localparam int MODE_DIFF_BIT = 1;
	localparam int MODE_BITS = 2;
	localparam int CH_PER_HALF = 16;

	// Reset values.
	localparam logic RESET_FRAC = 1'b0;
	localparam resolution_t RESET_RES = RES_12;

endpackage

// ==== rtl/result_format_if.sv ====
`timescale 1ns/1ns
`default_nettype none

interface result_format_if;
	logic [adc_result_pkg::RAW_W-1:0] raw;
	adc_result_pkg::resolution_t resolution;
	logic fractional;
	logic signed_fractional_select;
	logic differential;
	logic [adc_result_pkg::WORD_W-1:0] word;

	modport source(output raw, output resolution, output fractional, output signed_fractional_select,
		output differential, input word);
	modport formatter(input raw, input resolution, input fractional, input signed_fractional_select,
		input differential, output word);
endinterface

`default_nettype wire

// ==== rtl/result_formatter.sv ====
`timescale 1ns/1ns
`default_nettype none

module result_formatter (
	result_format_if.formatter fmt // Raw result in, formatted word out.
);
	localparam int RAW_W = adc_result_pkg::RAW_W;
	localparam int PAD_W = adc_result_pkg::FRAC_PAD_W;

	logic [3:0] drop;
	logic [RAW_W-1:0] left;
	logic [RAW_W-1:0] aligned;
	logic [RAW_W-1:0] int_signed;
	logic [RAW_W-1:0] int_unsigned;
	logic [3:0] res_gap;

	// Bits above the core's width are pushed out by the left alignment.
	assign res_gap = 4'(adc_result_pkg::RES_12) - 4'(fmt.resolution);
	assign drop = 4'(res_gap * adc_result_pkg::RES_STEP_BITS);
	assign left = fmt.raw << drop;
	// A differential code is offset binary; flipping its top bit makes it two's complement.
	assign aligned = left ^ {fmt.signed_fractional_select & fmt.differential, {(RAW_W-1){1'b0}}};
	assign int_signed = RAW_W'($signed(aligned) >>> drop);
	assign int_unsigned = aligned >> drop;

	assign fmt.word = fmt.fractional ? {aligned, {PAD_W{1'b0}}} :
		fmt.signed_fractional_select ? {{PAD_W{int_signed[RAW_W-1]}}, int_signed} :
		{{PAD_W{1'b0}}, int_unsigned};

endmodule

`default_nettype wire

// ==== verification/adc_result_chk.sv ====
`timescale 1ns/1ns
`default_nettype none

module adc_result_chk #(
	parameter int NUM_CH = 16,
	parameter int NUM_CORES = 4
) (
	input wire logic REF_CLK, // Clock.
	input wire logic RST, // Reset, active high.
	input wire logic PSEL, // APB select.
	input wire logic PENABLE, // APB access phase.
	input wire logic PWRITE, // APB direction.
	input wire logic [adc_result_pkg::ADDR_W-1:0] PADDR, // APB address.
	input wire logic [adc_result_pkg::DATA_W-1:0] PRDATA, // APB read data.
	input wire logic PREADY, // APB done.
	input wire logic PSLVERR, // APB error.
	input wire logic IRQ, // Summary interrupt.
	input wire logic [NUM_CH-1:0] CH_READY, // Ready flags.
	input wire logic RESULT_VALID, // Result strobe.
	input wire logic [4:0] RESULT_CHANNEL // Result channel.
);
	wire logic wr_acc = PSEL && PENABLE && PREADY && PWRITE;
	wire logic buf_rd = PSEL && PENABLE && PREADY && !PWRITE && PADDR[11:7] == 5'h02
		&& PADDR[1:0] == 2'h0 && !PSLVERR;
	wire logic [4:0] rd_ch = PADDR[6:2];

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	property p_ready_set;
		RESULT_VALID && RESULT_CHANNEL < NUM_CH |-> ##2 CH_READY[$past(RESULT_CHANNEL, 2)];
	endproperty
	a_ready_set: assert property (p_ready_set)
		else $error("ready flag not raised after a result");
	property p_ready_rise;
		(CH_READY & ~$past(CH_READY)) != '0 |-> $past(RESULT_VALID, 2);
	endproperty
	a_ready_rise: assert property (p_ready_rise)
		else $error("channel request rose without a result");
	property p_read_clear;
		buf_rd && !RESULT_VALID && !$past(RESULT_VALID) |-> ##2 !CH_READY[$past(rd_ch, 2)];
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("buffer read left the ready flag set");
	property p_ready_fall;
		($past(CH_READY) & ~CH_READY) != '0 |-> $past(buf_rd, 2);
	endproperty
	a_ready_fall: assert property (p_ready_fall)
		else $error("ready flag fell without a buffer read");
	property p_irq_rise;
		$rose(IRQ) |-> $past(RESULT_VALID, 2) || $past(wr_acc, 2);
	endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("interrupt rose without a cause");
	property p_irq_fall;
		$fell(IRQ) |-> $past(wr_acc, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt fell without a write");
	property p_word16;
		buf_rd |-> PRDATA[31:16] == 16'h0000;
	endproperty
	a_word16: assert property (p_word16)
		else $error("buffer word wider than 16 bits");
	property p_rdata_idle;
		!PREADY |-> PRDATA == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside an access");
	property p_same_cycle;
		buf_rd && RESULT_VALID && RESULT_CHANNEL == rd_ch |-> ##2 CH_READY[$past(rd_ch, 2)];
	endproperty
	a_same_cycle: assert property (p_same_cycle)
		else $error("store during read was acknowledged");

	c_same_cycle: cover property (buf_rd && RESULT_VALID && RESULT_CHANNEL == rd_ch);
	c_irq: cover property ($rose(IRQ));
	c_error: cover property (PREADY && PSLVERR);
endmodule

`default_nettype wire

// ==== verification/core_result_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module core_result_model #(
	parameter int CORE_W = 3
) (
	input wire logic clk, // System clock.
	output logic valid, // Result strobe.
	output logic [4:0] channel, // Result channel.
	output logic [CORE_W-1:0] core, // Converting core.
	output logic [11:0] data // Raw code.
);
	initial begin
		valid = 1'b0;
		channel = 5'h00;
		core = '0;
		data = 12'h000;
	end

	// Idle lines carry the inverse of the last result so that stale data is never mistaken for new.
	task automatic send(input logic [4:0] ch, input logic [CORE_W-1:0] co, input logic [11:0] d);
		@(posedge clk);
		valid <= 1'b1;
		channel <= ch;
		core <= co;
		data <= d;
		@(posedge clk);
		valid <= 1'b0;
		channel <= ~ch;
		core <= ~co;
		data <= ~d;
	endtask
endmodule

`default_nettype wire

// ==== verification/adc_result_buffer_formatter_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

bind adc_result_buffer_formatter adc_result_chk #(.NUM_CH(NUM_CH), .NUM_CORES(NUM_CORES)) chk (
	.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
	.CH_READY(CH_READY), .RESULT_VALID(RESULT_VALID), .RESULT_CHANNEL(RESULT_CHANNEL));

module adc_result_buffer_formatter_tb;
	typedef struct {
		logic [4:0] ch;
		logic [2:0] core;
		logic [1:0] res;
		logic frac;
		logic [1:0] mode;
		logic [11:0] raw;
		logic [15:0] exp;
	} row_s;
	row_s rows [9] = '{
		'{5'h00, 3'h0, 2'h3, 1'b0, 2'h0, 12'hA5C, 16'h0A5C},
		'{5'h01, 3'h1, 2'h3, 1'b0, 2'h1, 12'h9C3, 16'hF9C3},
		'{5'h02, 3'h2, 2'h3, 1'b1, 2'h0, 12'hA5C, 16'hA5C0},
		'{5'h03, 3'h3, 2'h3, 1'b1, 2'h3, 12'h234, 16'hA340},
		'{5'h04, 3'h4, 2'h2, 1'b0, 2'h1, 12'h3FF, 16'hFFFF},
		'{5'h05, 3'h0, 2'h1, 1'b0, 2'h2, 12'hF81, 16'h0081},
		'{5'h06, 3'h1, 2'h0, 1'b1, 2'h0, 12'h02A, 16'hA800},
		'{5'h07, 3'h4, 2'h1, 1'b0, 2'h3, 12'h010, 16'hFF90},
		'{5'h0F, 3'h2, 2'h2, 1'b1, 2'h1, 12'h201, 16'h8040}};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rd_q;
	logic err_q;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, irq, rv;
	wire logic [15:0] ch_ready;
	wire logic [4:0] rch;
	wire logic [2:0] rcore;
	wire logic [11:0] rdat;
	int error_cnt = 0;
	int tests_run = 0;

	always #10 ref_clk = ~ref_clk;

	adc_result_buffer_formatter #(.NUM_CH(16), .NUM_CORES(4)) dut (
		.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .IRQ(irq), .CH_READY(ch_ready), .RESULT_VALID(rv),
		.RESULT_CHANNEL(rch), .RESULT_CORE(rcore), .RESULT_DATA(rdat));
	core_result_model #(.CORE_W(3)) pm (.clk(ref_clk), .valid(rv), .channel(rch),
		.core(rcore), .data(rdat));

	task automatic complete_run();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_q, exp);
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		complete_run();
	end

	initial begin
		row_s r;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rdchk(adc_result_pkg::CTRL_OFS, 32'h0000_0300);
		rdchk(adc_result_pkg::STATUS_LOW_OFS, 32'h0000_0000);
		for (int i = 0; i < 9; i++) begin
			r = rows[i];
			// The unused resolution field is set apart so that a wrong core choice shows.
			wr(adc_result_pkg::CTRL_OFS, {22'h0, r.core == 3'h4 ? r.res : ~r.res, 7'h0, r.frac});
			if (r.core != 3'h4) begin
				wr(adc_result_pkg::CORE_CFG_BASE + 12'(4 * r.core), {30'h0, r.res});
			end
			wr(adc_result_pkg::MODE_LOW_OFS, 32'(r.mode) << (2 * r.ch));
			pm.send(r.ch, r.core, r.raw);
			rdchk(adc_result_pkg::STATUS_LOW_OFS, 32'h1 << r.ch);
			chk({16'h0, ch_ready}, 32'h1 << r.ch);
			rdchk(adc_result_pkg::BUFFER_BASE + 12'(4 * r.ch), {16'h0, r.exp});
			rdchk(adc_result_pkg::STATUS_LOW_OFS, 32'h0000_0000);
		end
		wr(adc_result_pkg::BUFFER_BASE, 32'h0000_FFFF);
		rdchk(adc_result_pkg::BUFFER_BASE, 32'h0000_0A5C);
		wr(adc_result_pkg::CTRL_OFS, 32'h0000_0300);
		wr(adc_result_pkg::CORE_CFG_BASE, 32'h0000_0003);
		wr(adc_result_pkg::MODE_LOW_OFS, 32'h0000_0000);
		pm.send(5'h08, 3'h0, 12'h111);
		pm.send(5'h08, 3'h0, 12'h222);
		rdchk(adc_result_pkg::BUFFER_BASE + 12'h020, 32'h0000_0222);
		rdchk(adc_result_pkg::STATUS_LOW_OFS, 32'h0000_0000);
		fork
			apb(1'b0, adc_result_pkg::BUFFER_BASE + 12'h020, 32'h0000_0000);
			begin
				@(posedge ref_clk);
				pm.send(5'h08, 3'h0, 12'h333);
			end
		join
		chk(rd_q, 32'h0000_0222);
		rdchk(adc_result_pkg::STATUS_LOW_OFS, 32'h0000_0100);
		rdchk(adc_result_pkg::BUFFER_BASE + 12'h020, 32'h0000_0333);
		wr(adc_result_pkg::IRQ_STATUS_OFS, 32'hFFFF_FFFF);
		rdchk(adc_result_pkg::IRQ_STATUS_OFS, 32'h0000_0000);
		pm.send(5'h0A, 3'h0, 12'h005);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(adc_result_pkg::IRQ_MASK_OFS, 32'h0000_0200);
		pm.send(5'h09, 3'h0, 12'h005);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(adc_result_pkg::IRQ_STATUS_OFS, 32'h0000_0200);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		rdchk(adc_result_pkg::IRQ_STATUS_OFS, 32'h0000_0400);
		chk({16'h0, ch_ready}, 32'h0000_0600);
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk({rd_q[30:0], err_q}, 32'h0000_0001);
		apb(1'b0, adc_result_pkg::BUFFER_BASE + 12'h002, 32'h0000_0000);
		chk({rd_q[30:0], err_q}, 32'h0000_0001);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		chk({16'h0, ch_ready}, 32'h0000_0000);
		rdchk(adc_result_pkg::BUFFER_BASE, 32'h0000_0000);
		rdchk(adc_result_pkg::CTRL_OFS, 32'h0000_0300);
		complete_run();
	end
endmodule

`default_nettype wire
